//--- dtc_consts.svh
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// Register byte offsets
`define DTC_OFS_CTRL 8'h00
`define DTC_OFS_CLKSEL 8'h04
`define DTC_OFS_PRESC 8'h08
`define DTC_OFS_CNT1 8'h0c
`define DTC_OFS_CNT2 8'h10
`define DTC_OFS_RCA 8'h14
`define DTC_OFS_RCB 8'h18
`define DTC_OFS_PEND 8'h1c
`define DTC_OFS_IEN 8'h20

// Control register fields
`define DTC_CTRL_MODE_LSB 0
`define DTC_CTRL_LEVEL 2
`define DTC_CTRL_TOG_EN 3
`define DTC_CTRL_EXT_RISE 4
`define DTC_CTRL_ACC_HIGH 5
`define DTC_CTRL_CAPA_RISE 6
`define DTC_CTRL_CAPB_RISE 7
`define DTC_CTRL_PRESET_A 8
`define DTC_CTRL_PRESET_B 9
`define DTC_CTRL_W 10

// Clock select fields
`define DTC_CLKSEL_SRC1_LSB 0
`define DTC_CLKSEL_SRC2_LSB 4

// Pending and enable bit positions
`define DTC_PEND_A 0
`define DTC_PEND_B 1
`define DTC_PEND_C 2
`define DTC_PEND_D 3

// Reset values and the counter top value
`define DTC_RST_CTRL 10'h000
`define DTC_RST_CLKSEL 8'h00
`define DTC_RST_PRESC 5'h00
`define DTC_RST_CNT 16'h0000
`define DTC_RST_FLAGS 4'h0
`define DTC_CNT_TOP 16'hffff

`endif

//--- dtc_pkg.sv
package dtc_pkg;

   typedef enum logic [1:0] {
      MODE_PWM,
      MODE_CAPT,
      MODE_DUAL,
      MODE_CAPT_TMR
   } dtc_mode_t;

   typedef enum logic [2:0] {
      SRC_NONE,
      SRC_PRESC,
      SRC_EXT,
      SRC_PULSE,
      SRC_SLOW
   } dtc_src_t;

   // Edge of chosen polarity between two samples
   function automatic logic dtc_edge(input logic cur, input logic prev, input logic rise);
      dtc_edge = rise ? (cur & ~prev) : (~cur & prev);
   endfunction

endpackage

//--- dtc_tick_if.sv
`timescale 1ns/1ps
interface dtc_tick_if;
   logic presc_tick;
   logic slow_tick;
   modport src (output presc_tick, output slow_tick);
   modport snk (input presc_tick, input slow_tick);
endinterface

//--- dtc_presc.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_presc import dtc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] div_i,
   input wire logic slow_clk_i,
   dtc_tick_if.src tk
);
   logic [4:0] cnt_q;
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // Hidden down counter, divides by divisor plus one
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= `DTC_RST_PRESC;
      end else if (cnt_q == 5'h00) begin
         cnt_q <= div_i;
      end else begin
         cnt_q <= cnt_q - 5'h01;
      end
   end
   assign tk.presc_tick = (cnt_q == 5'h00);

   // Slow clock synchroniser; needs four system clocks per slow period
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= slow_clk_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   // Edges only seen while clk runs, so a stopped clock freezes the count
   assign tk.slow_tick = s2_q & ~s3_q;
endmodule

//--- dtc_clksel.sv
`timescale 1ns/1ps
module dtc_clksel import dtc_pkg::*; (
   input wire logic [2:0] src_i,
   input wire logic tb_busy_i,
   input wire logic ext_evt_i,
   input wire logic acc_gate_i,
   dtc_tick_if.snk tk,
   output logic tick_o
);
   // One count enable per selected source
   always_comb begin
      case (dtc_src_t'(src_i))
         SRC_PRESC: tick_o = tk.presc_tick;
         SRC_EXT: tick_o = ext_evt_i & ~tb_busy_i;
         SRC_PULSE: tick_o = tk.presc_tick & acc_gate_i & ~tb_busy_i;
         SRC_SLOW: tick_o = tk.slow_tick;
         default: tick_o = 1'b0;
      endcase
   end
endmodule

//--- dtc_top.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_top import dtc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic first_io_pin_i,
   output logic first_io_pin_o,
   output logic first_io_pin_oe_o,
   input wire logic second_io_pin_i,
   input wire logic slow_clk_i,
   output logic irq_timer1_o,
   output logic irq_timer2_o
);
   logic [`DTC_CTRL_W-1:0] ctrl_q;
   logic [7:0] clksel_q;
   logic [4:0] prescale_divisor_q;
   logic [15:0] primary_counter_q, secondary_counter_q;
   logic [15:0] reload_capture_a_q, reload_capture_b_q;
   logic [3:0] pend_q, ien_q;
   dtc_mode_t mode_prev_q;
   logic reload_b_next_q, ta_prev_q, tb_prev_q;
   dtc_mode_t mode;
   logic [2:0] src1, src2;
   logic wr_ctrl, wr_cnt1, wr_cnt2, wr_pend;
   logic tick1, tick2, uf1, uf2;
   logic capt, cap_a, cap_b, ext_evt, acc_gate;
   logic [3:0] pend_set, pend_clr, pend_d;

   dtc_tick_if tk ();

   // Decoded controls
   assign mode = dtc_mode_t'(ctrl_q[`DTC_CTRL_MODE_LSB +: 2]);
   assign src1 = clksel_q[`DTC_CLKSEL_SRC1_LSB +: 3];
   assign src2 = clksel_q[`DTC_CLKSEL_SRC2_LSB +: 3];
   assign capt = (mode == MODE_CAPT);
   assign wr_ctrl = wr_i && (addr_i == `DTC_OFS_CTRL);
   assign wr_cnt1 = wr_i && (addr_i == `DTC_OFS_CNT1);
   assign wr_cnt2 = wr_i && (addr_i == `DTC_OFS_CNT2);
   assign wr_pend = wr_i && (addr_i == `DTC_OFS_PEND);

   // Second pin event and gate terms
   assign ext_evt = dtc_edge(second_io_pin_i, tb_prev_q, ctrl_q[`DTC_CTRL_EXT_RISE]);
   assign acc_gate = (second_io_pin_i == ctrl_q[`DTC_CTRL_ACC_HIGH]);
   // Capture edges, each with its own polarity
   assign cap_a = capt && dtc_edge(first_io_pin_i, ta_prev_q, ctrl_q[`DTC_CTRL_CAPA_RISE]);
   assign cap_b = capt && dtc_edge(second_io_pin_i, tb_prev_q, ctrl_q[`DTC_CTRL_CAPB_RISE]);

   // Pin history for edge detection
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ta_prev_q <= 1'b0;
         tb_prev_q <= 1'b0;
      end else begin
         ta_prev_q <= first_io_pin_i;
         tb_prev_q <= second_io_pin_i;
      end
   end

   dtc_presc u_presc (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .div_i(prescale_divisor_q),
      .slow_clk_i(slow_clk_i),
      .tk(tk.src)
   );

   // Primary loses pin-based sources while the second pin captures
   dtc_clksel u_sel1 (
      .src_i(src1),
      .tb_busy_i(capt),
      .ext_evt_i(ext_evt),
      .acc_gate_i(acc_gate),
      .tk(tk.snk),
      .tick_o(tick1)
   );

   dtc_clksel u_sel2 (
      .src_i(src2),
      .tb_busy_i(1'b0),
      .ext_evt_i(ext_evt),
      .acc_gate_i(acc_gate),
      .tk(tk.snk),
      .tick_o(tick2)
   );

   // Underflow is a count taken at zero
   assign uf1 = tick1 && (primary_counter_q == 16'h0000);
   assign uf2 = tick2 && (secondary_counter_q == 16'h0000);

   // Plain registers written by software
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         clksel_q <= `DTC_RST_CLKSEL;
         prescale_divisor_q <= `DTC_RST_PRESC;
         ien_q <= `DTC_RST_FLAGS;
      end else if (wr_i) begin
         case (addr_i)
            `DTC_OFS_CLKSEL: clksel_q <= wdata_i[7:0];
            `DTC_OFS_PRESC: prescale_divisor_q <= wdata_i[4:0];
            `DTC_OFS_IEN: ien_q <= wdata_i[3:0];
            default: ;
         endcase
      end
   end

   // Control; hardware toggles the level bit, a software write wins
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `DTC_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_q <= wdata_i[`DTC_CTRL_W-1:0];
      end else if (uf1 && ctrl_q[`DTC_CTRL_TOG_EN] && !capt) begin
         ctrl_q[`DTC_CTRL_LEVEL] <= ~ctrl_q[`DTC_CTRL_LEVEL];
      end
   end

   // Alternation pointer back to A on reset, mode entry or stop
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reload_b_next_q <= 1'b0;
         mode_prev_q <= MODE_PWM;
      end else begin
         mode_prev_q <= mode;
         if (mode != MODE_PWM || mode_prev_q != MODE_PWM || dtc_src_t'(src1) == SRC_NONE) begin
            reload_b_next_q <= 1'b0;
         end else if (uf1) begin
            reload_b_next_q <= ~reload_b_next_q;
         end
      end
   end

   // Primary counter: reload, capture preset or free wrap
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         primary_counter_q <= `DTC_RST_CNT;
      end else if (wr_cnt1) begin
         primary_counter_q <= wdata_i;
      end else if ((cap_a && ctrl_q[`DTC_CTRL_PRESET_A]) || (cap_b && ctrl_q[`DTC_CTRL_PRESET_B])) begin
         primary_counter_q <= `DTC_CNT_TOP;
      end else if (uf1) begin
         case (mode)
            MODE_PWM: primary_counter_q <= reload_b_next_q ? reload_capture_b_q : reload_capture_a_q;
            MODE_CAPT: primary_counter_q <= `DTC_CNT_TOP;
            default: primary_counter_q <= reload_capture_a_q;
         endcase
      end else if (tick1) begin
         primary_counter_q <= primary_counter_q - 16'h0001;
      end
   end

   // Secondary counter, preloadable by software
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         secondary_counter_q <= `DTC_RST_CNT;
      end else if (wr_cnt2) begin
         secondary_counter_q <= wdata_i;
      end else if (uf2 && mode == MODE_DUAL) begin
         secondary_counter_q <= reload_capture_b_q;
      end else if (tick2) begin
         secondary_counter_q <= secondary_counter_q - 16'h0001;
      end
   end

   // Reload or capture registers; capture keeps the pre-preset value
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         reload_capture_a_q <= `DTC_RST_CNT;
         reload_capture_b_q <= `DTC_RST_CNT;
      end else begin
         if (cap_a) begin
            reload_capture_a_q <= primary_counter_q;
         end else if (wr_i && addr_i == `DTC_OFS_RCA) begin
            reload_capture_a_q <= wdata_i;
         end
         if (cap_b) begin
            reload_capture_b_q <= primary_counter_q;
         end else if (wr_i && addr_i == `DTC_OFS_RCB) begin
            reload_capture_b_q <= wdata_i;
         end
      end
   end

   // Pending flag sources per mode
   always_comb begin
      pend_set = 4'h0;
      case (mode)
         MODE_PWM: begin
            pend_set[`DTC_PEND_A] = uf1 && !reload_b_next_q;
            pend_set[`DTC_PEND_B] = uf1 && reload_b_next_q;
         end
         MODE_CAPT: begin
            pend_set[`DTC_PEND_A] = cap_a;
            pend_set[`DTC_PEND_B] = cap_b;
            pend_set[`DTC_PEND_C] = uf1;
         end
         default: pend_set[`DTC_PEND_A] = uf1;
      endcase
      pend_set[`DTC_PEND_D] = uf2;
   end

   // Write one to clear; a same-cycle event wins
   assign pend_clr = wr_pend ? wdata_i[3:0] : 4'h0;
   assign pend_d = (pend_q & ~pend_clr) | pend_set;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= `DTC_RST_FLAGS;
      end else begin
         pend_q <= pend_d;
      end
   end

   // Interrupt lines from flags and enables
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_timer1_o <= 1'b0;
         irq_timer2_o <= 1'b0;
      end else begin
         irq_timer1_o <= |(pend_q[2:0] & ien_q[2:0]);
         irq_timer2_o <= pend_q[`DTC_PEND_D] & ien_q[`DTC_PEND_D];
      end
   end

   // First pin drive; capture mode leaves it an input
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         first_io_pin_o <= 1'b0;
         first_io_pin_oe_o <= 1'b0;
      end else begin
         first_io_pin_o <= ctrl_q[`DTC_CTRL_LEVEL];
         first_io_pin_oe_o <= ctrl_q[`DTC_CTRL_TOG_EN] && !capt;
      end
   end

   // Read data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            `DTC_OFS_CTRL: rdata_o <= {6'h00, ctrl_q};
            `DTC_OFS_CLKSEL: rdata_o <= {8'h00, clksel_q};
            `DTC_OFS_PRESC: rdata_o <= {11'h000, prescale_divisor_q};
            `DTC_OFS_CNT1: rdata_o <= primary_counter_q;
            `DTC_OFS_CNT2: rdata_o <= secondary_counter_q;
            `DTC_OFS_RCA: rdata_o <= reload_capture_a_q;
            `DTC_OFS_RCB: rdata_o <= reload_capture_b_q;
            `DTC_OFS_PEND: rdata_o <= {12'h000, pend_q};
            `DTC_OFS_IEN: rdata_o <= {12'h000, ien_q};
            default: rdata_o <= 16'h0000;
         endcase
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // Checks
   sequence s_reload_a;
      mode == MODE_PWM && mode_prev_q == MODE_PWM && uf1 && !reload_b_next_q && !wr_cnt1;
   endsequence

   sequence s_reload_b;
      mode == MODE_PWM && mode_prev_q == MODE_PWM && uf1 && reload_b_next_q && !wr_cnt1;
   endsequence

   property p_reload_a;
      @(posedge clk_i) disable iff (rst_i)
      s_reload_a |=> primary_counter_q == $past(reload_capture_a_q) && pend_q[`DTC_PEND_A];
   endproperty
   a_reload_a: assert property (p_reload_a) else $error("reload from A missing");

   property p_alternate;
      @(posedge clk_i) disable iff (rst_i)
      s_reload_a ##1 (!wr_ctrl && dtc_src_t'(src1) != SRC_NONE && mode == MODE_PWM) |-> reload_b_next_q;
   endproperty
   a_alternate: assert property (p_alternate) else $error("reload did not alternate");

   property p_reload_b;
      @(posedge clk_i) disable iff (rst_i)
      s_reload_b |=> primary_counter_q == $past(reload_capture_b_q) && pend_q[`DTC_PEND_B];
   endproperty
   a_reload_b: assert property (p_reload_b) else $error("reload from B missing");

   property p_restart_a;
      @(posedge clk_i) disable iff (rst_i)
      dtc_src_t'(src1) == SRC_NONE |=> !reload_b_next_q;
   endproperty
   a_restart_a: assert property (p_restart_a) else $error("stop did not restart at A");

   property p_toggle;
      @(posedge clk_i) disable iff (rst_i)
      mode == MODE_PWM && uf1 && ctrl_q[`DTC_CTRL_TOG_EN] && !wr_ctrl
         |=> ctrl_q[`DTC_CTRL_LEVEL] != $past(ctrl_q[`DTC_CTRL_LEVEL]) ##1
             first_io_pin_o == $past(ctrl_q[`DTC_CTRL_LEVEL]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("pin did not toggle");

   property p_capture;
      @(posedge clk_i) disable iff (rst_i)
      cap_a |=> reload_capture_a_q == $past(primary_counter_q);
   endproperty
   a_capture: assert property (p_capture) else $error("capture A wrong");

   property p_preset;
      @(posedge clk_i) disable iff (rst_i)
      cap_b && ctrl_q[`DTC_CTRL_PRESET_B] && !wr_cnt1 |=> primary_counter_q == `DTC_CNT_TOP && pend_q[`DTC_PEND_B];
   endproperty
   a_preset: assert property (p_preset) else $error("preset missing");

   property p_uf_c;
      @(posedge clk_i) disable iff (rst_i)
      capt && uf1 && !cap_a && !cap_b && !wr_cnt1 |=> primary_counter_q == `DTC_CNT_TOP && pend_q[`DTC_PEND_C];
   endproperty
   a_uf_c: assert property (p_uf_c) else $error("underflow C wrong");

   property p_no_pin_src;
      @(posedge clk_i) disable iff (rst_i)
      capt && (dtc_src_t'(src1) == SRC_EXT || dtc_src_t'(src1) == SRC_PULSE) |-> !tick1;
   endproperty
   a_no_pin_src: assert property (p_no_pin_src) else $error("primary ran on pin source");

   property p_stopped;
      @(posedge clk_i) disable iff (rst_i)
      dtc_src_t'(src1) == SRC_NONE && !wr_cnt1 && !cap_a && !cap_b |=> $stable(primary_counter_q);
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped counter moved");

   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      pend_q[`DTC_PEND_D] && !(wr_pend && wdata_i[`DTC_PEND_D]) |=> pend_q[`DTC_PEND_D];
   endproperty
   a_hold: assert property (p_hold) else $error("pending D lost");

   property p_irq2;
      @(posedge clk_i) disable iff (rst_i)
      uf2 && ien_q[`DTC_PEND_D] && !wr_i |=> pend_q[`DTC_PEND_D] ##1 irq_timer2_o;
   endproperty
   a_irq2: assert property (p_irq2) else $error("irq two missing");
endmodule

//--- dtc_pins_model.sv
`timescale 1ns/1ps
// Far-side sources for both pins and the slow clock
module dtc_pins_model (
   input wire logic clk_i,
   input wire logic a_lvl_i,
   input wire logic b_lvl_i,
   input wire logic slow_en_i,
   output logic first_pin_o,
   output logic second_pin_o,
   output logic slow_clk_o
);
   logic [1:0] slow_div_q;

   // Known levels before the first edge
   initial begin
      first_pin_o = 1'b0;
      second_pin_o = 1'b0;
      slow_clk_o = 1'b0;
      slow_div_q = 2'h0;
   end

   // Levels move only on clock edges, so each lasts at least a full cycle
   always @(posedge clk_i) begin
      first_pin_o <= a_lvl_i;
      second_pin_o <= b_lvl_i;
   end

   // Slow clock at clk/8, still while disabled; stays well below quarter rate
   always @(posedge clk_i) begin
      slow_div_q <= slow_en_i ? slow_div_q + 2'h1 : 2'h0;
      if (slow_en_i && slow_div_q == 2'h3) begin
         slow_clk_o <= ~slow_clk_o;
      end
   end
endmodule

//--- dtc_top_test.sv
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_top_test;
   logic clk_i, rst_i, wr_i, rd_i, a_lvl, b_lvl, slow_en;
   logic first_io_pin_i, first_io_pin_o, first_io_pin_oe_o, second_io_pin_i, slow_clk_i;
   logic irq_timer1_o, irq_timer2_o;
   logic [7:0] addr_i;
   logic [15:0] wdata_i, rdata_o, v;
   int mismatches, total_checks, n;

   dtc_top dtc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .first_io_pin_i(first_io_pin_i),
      .first_io_pin_o(first_io_pin_o), .first_io_pin_oe_o(first_io_pin_oe_o),
      .second_io_pin_i(second_io_pin_i), .slow_clk_i(slow_clk_i),
      .irq_timer1_o(irq_timer1_o), .irq_timer2_o(irq_timer2_o));
   dtc_pins_model dtc_pins_model_inst (.clk_i(clk_i), .a_lvl_i(a_lvl), .b_lvl_i(b_lvl),
      .slow_en_i(slow_en), .first_pin_o(first_io_pin_i), .second_pin_o(second_io_pin_i),
      .slow_clk_o(slow_clk_i));

   // 50 MHz system clock
   always #10 clk_i = ~clk_i;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   // Tolerance of one tick, since start phase of a count is not pinned down
   task automatic near(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check(name, {15'h0, (seen >= exp - 16'h1) && (seen <= exp + 16'h1)}, 16'h0001);
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic pins(input logic a, input logic b);
      @(posedge clk_i);
      a_lvl <= a;
      b_lvl <= b;
      cyc(4);
   endtask

   // Waits for the PWM pin to reach a level, then counts cycles it holds it
   task automatic measure(input logic lvl, output int k);
      int w;
      w = 0;
      while (first_io_pin_o !== lvl && w < 200) begin
         @(posedge clk_i);
         #1;
         w++;
      end
      k = 0;
      while (first_io_pin_o === lvl && k < 200) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (k >= 200 || w >= 200) begin
         mismatches++;
         close_out();
      end
   endtask

   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 16'h0000;
      a_lvl = 1'b0;
      b_lvl = 1'b0;
      slow_en = 1'b0;
      mismatches = 0;
      total_checks = 0;
      cyc(3);
      rst_i <= 1'b0;
      // Reset values and an unmapped place
      rd(`DTC_OFS_CTRL, v);
      check("ctrl", v, 16'h0000);
      rd(`DTC_OFS_PEND, v);
      check("pend", v, 16'h0000);
      wr(8'h24, 16'hffff);
      rd(8'h24, v);
      check("unmapped", v, 16'h0000);
      // Stopped counter, then prescaler divide by five over 101 cycles
      wr(`DTC_OFS_CNT1, 16'h0030);
      cyc(20);
      rd(`DTC_OFS_CNT1, v);
      check("cnt1 held", v, 16'h0030);
      wr(`DTC_OFS_PRESC, 16'h0004);
      wr(`DTC_OFS_CLKSEL, 16'h0001);
      cyc(99);
      wr(`DTC_OFS_CLKSEL, 16'h0000);
      rd(`DTC_OFS_CNT1, v);
      near("cnt1 prescaled", v, 16'h001c);
      // PWM: level bit first, then alternate reloads A=3, B=5
      wr(`DTC_OFS_PRESC, 16'h0000);
      wr(`DTC_OFS_RCA, 16'h0003);
      wr(`DTC_OFS_RCB, 16'h0005);
      wr(`DTC_OFS_CNT1, 16'h0000);
      wr(`DTC_OFS_CTRL, 16'h000c);
      cyc(2);
      check("pin level", {15'h0, first_io_pin_o}, 16'h0001);
      check("pin enable", {15'h0, first_io_pin_oe_o}, 16'h0001);
      wr(`DTC_OFS_CLKSEL, 16'h0001);
      measure(1'b0, n);
      check("low time", n[15:0], 16'h0004);
      measure(1'b1, n);
      check("high time", n[15:0], 16'h0006);
      measure(1'b0, n);
      check("low time 2", n[15:0], 16'h0004);
      measure(1'b1, n);
      check("high time 2", n[15:0], 16'h0006);
      wr(`DTC_OFS_CLKSEL, 16'h0000);
      rd(`DTC_OFS_PEND, v);
      check("pend reloads", v, 16'h0003);
      // Restart from no clock must take A first
      wr(`DTC_OFS_PEND, 16'h000f);
      wr(`DTC_OFS_CNT1, 16'h0000);
      wr(`DTC_OFS_CLKSEL, 16'h0001);
      cyc(2);
      rd(`DTC_OFS_PEND, v);
      check("pend restart", v, 16'h0001);
      wr(`DTC_OFS_CLKSEL, 16'h0000);
      wr(`DTC_OFS_IEN, 16'h0001);
      cyc(2);
      check("irq1 on", {15'h0, irq_timer1_o}, 16'h0001);
      wr(`DTC_OFS_PEND, 16'h000f);
      cyc(2);
      check("irq1 off", {15'h0, irq_timer1_o}, 16'h0000);
      // Capture: A rising and B falling, both with preset
      wr(`DTC_OFS_CNT1, 16'h1234);
      wr(`DTC_OFS_CTRL, 16'h0341);
      cyc(2);
      check("pin enable mode2", {15'h0, first_io_pin_oe_o}, 16'h0000);
      pins(1'b1, 1'b0);
      rd(`DTC_OFS_RCA, v);
      check("capture a", v, 16'h1234);
      rd(`DTC_OFS_CNT1, v);
      check("preset", v, 16'hffff);
      pins(1'b1, 1'b1);
      rd(`DTC_OFS_RCB, v);
      check("capture b rise", v, 16'h0005);
      wr(`DTC_OFS_CNT1, 16'h0777);
      pins(1'b1, 1'b0);
      rd(`DTC_OFS_RCB, v);
      check("capture b fall", v, 16'h0777);
      rd(`DTC_OFS_CNT1, v);
      check("preset b", v, 16'hffff);
      rd(`DTC_OFS_PEND, v);
      check("pend captures", v, 16'h0003);
      // Pin-based source leaves counter 1 stopped in capture mode
      wr(`DTC_OFS_CTRL, 16'h0141);
      wr(`DTC_OFS_CNT1, 16'h0005);
      wr(`DTC_OFS_CLKSEL, 16'h0002);
      pins(1'b1, 1'b1);
      pins(1'b1, 1'b0);
      rd(`DTC_OFS_CNT1, v);
      check("cnt1 ext blocked", v, 16'h0005);
      wr(`DTC_OFS_CNT1, 16'h0000);
      wr(`DTC_OFS_CLKSEL, 16'h0001);
      cyc(3);
      wr(`DTC_OFS_CLKSEL, 16'h0000);
      rd(`DTC_OFS_PEND, v);
      check("pend underflow", v & 16'h0004, 16'h0004);
      // Slow clock on counter 2 in capture mode, through underflow
      wr(`DTC_OFS_IEN, 16'h0008);
      wr(`DTC_OFS_CNT2, 16'h0003);
      wr(`DTC_OFS_CLKSEL, 16'h0040);
      @(posedge clk_i);
      slow_en <= 1'b1;
      cyc(80);
      slow_en <= 1'b0;
      rd(`DTC_OFS_CNT2, v);
      near("cnt2 slow", v, 16'hfff9);
      cyc(2);
      check("irq2", {15'h0, irq_timer2_o}, 16'h0001);
      // External events on counter 2, rising then falling edges
      wr(`DTC_OFS_CTRL, 16'h0010);
      wr(`DTC_OFS_CNT2, 16'h0010);
      wr(`DTC_OFS_CLKSEL, 16'h0020);
      repeat (5) begin
         pins(1'b0, 1'b1);
         pins(1'b0, 1'b0);
      end
      rd(`DTC_OFS_CNT2, v);
      check("ext rise", v, 16'h000b);
      wr(`DTC_OFS_CTRL, 16'h0000);
      repeat (3) begin
         pins(1'b0, 1'b1);
         pins(1'b0, 1'b0);
      end
      rd(`DTC_OFS_CNT2, v);
      check("ext fall", v, 16'h0008);
      // Pulse accumulate: counts only the 20 cycles the pin is high
      wr(`DTC_OFS_CNT2, 16'h0040);
      wr(`DTC_OFS_CTRL, 16'h0020);
      wr(`DTC_OFS_CLKSEL, 16'h0030);
      pins(1'b0, 1'b1);
      cyc(15);
      pins(1'b0, 1'b0);
      cyc(20);
      rd(`DTC_OFS_CNT2, v);
      check("pulse acc", v, 16'h002c);
      // Mode 3: primary reloads from A on underflow
      wr(`DTC_OFS_CTRL, 16'h0002);
      wr(`DTC_OFS_CNT1, 16'h0000);
      wr(`DTC_OFS_CLKSEL, 16'h0001);
      wr(`DTC_OFS_CLKSEL, 16'h0000);
      rd(`DTC_OFS_CNT1, v);
      check("mode3 reload", v, 16'h1233);
      close_out();
   end
endmodule
